// file: rtl/dcpc_pkg.sv
// Constants, pin bundle and data word of the converter pin control block.
// Assumes one 20 MHz system clock and a synchronous active high reset.
package dcpc_pkg;
    localparam logic [3:0] CAL_REG_ADDR = 4'h0;
    localparam int CAL_CMD_BIT = 0;
    localparam logic [15:0] CAL_REG_RESET = 16'h0000;
    localparam logic [15:0] CAL_LOW_MIN = 16'h0050;
    localparam logic [15:0] CAL_HIGH_MIN = 16'h0050;
    localparam logic [15:0] CAL_RUN_CYC = 16'h0100;
    localparam logic [3:0] OUT_CLK_HALF = 4'h2;
    localparam logic [4:0] SER_FRAME = 5'h14;
    localparam int FIFO_DEPTH = 16;
    localparam int PIN_COUNT = 13;

    typedef struct packed
    {
        logic full_power_down;
        logic second_channel_power_down;
        logic cal;
        logic resync_p;
        logic resync_n;
        logic resync_style;
        logic edge_select;
        logic edge_mid;
        logic amplitude_select;
        logic range_mid;
        logic cal_delay_select;
        logic cal_delay_mid;
        logic demux;
    } dcpc_pins_t;

    typedef struct packed
    {
        logic [7:0] first;
        logic [7:0] second;
    } dcpc_word_t;
endpackage

// file: rtl/dcpc_top.sv
// Output FIFO and the pin control and output formatting logic.
// Assumes pins are asynchronous and samples come from the core on i_clk.
`timescale 1ns/1ns
`default_nettype none

module dcpc_fifo
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
)
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    assign push = i_in_valid & o_in_ready;
    assign pop = o_out_valid & i_out_ready;
    assign o_out_valid = count != '0;
    assign o_out_data = mem[rd_ptr];

    always_comb
    begin
        next_count = count;
        if (push & ~pop)
            next_count = count + 1'b1;
        else if (pop & ~push)
            next_count = count - 1'b1;
    end

    always_ff @(posedge i_clk)
    begin
        if (push)
            mem[wr_ptr] <= i_in_data;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            o_in_ready <= 1'b0;
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            count <= next_count;
            o_in_ready <= next_count != (AW + 1)'(DEPTH);
        end
    end
endmodule

module dcpc_top
#(
    parameter int DEPTH = dcpc_pkg::FIFO_DEPTH,
    parameter logic [15:0] CAL_RUN = dcpc_pkg::CAL_RUN_CYC
)
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire dcpc_pkg::dcpc_pins_t i_pins,
    input wire logic i_sample_valid,
    input wire dcpc_pkg::dcpc_word_t i_sample,
    output logic o_sample_ready,
    output logic [7:0] o_first_channel_out,
    output logic [7:0] o_first_channel_out_b,
    output logic [7:0] o_second_out,
    output logic [7:0] o_second_out_b,
    output logic o_output_data_clock,
    output logic o_first_active,
    output logic o_second_active,
    output logic o_cal_running,
    output logic o_long_cal_delay,
    output logic o_amplitude_reduced,
    output logic o_extended_mode,
    output logic o_interleave,
    output logic o_ddr
);
    // ***********************************************************
    // Pin synchronisers
    // ***********************************************************
    logic [dcpc_pkg::PIN_COUNT-1:0] sync1;
    logic [dcpc_pkg::PIN_COUNT-1:0] sync2;
    dcpc_pkg::dcpc_pins_t pin;

    for (genvar i = 0; i < dcpc_pkg::PIN_COUNT; i++)
    begin : g_sync
        always_ff @(posedge i_clk)
        begin
            if (i_sys_rst)
            begin
                sync1[i] <= 1'b0;
                sync2[i] <= 1'b0;
            end
            else
            begin
                sync1[i] <= i_pins[i];
                sync2[i] <= sync1[i];
            end
        end
    end
    assign pin = dcpc_pkg::dcpc_pins_t'(sync2);

    // ***********************************************************
    // Mode decode
    // ***********************************************************
    logic edge_rise;
    logic demux;

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_extended_mode <= 1'b0;
            o_ddr <= 1'b0;
            edge_rise <= 1'b0;
            o_interleave <= 1'b0;
            o_long_cal_delay <= 1'b0;
            o_amplitude_reduced <= 1'b0;
            demux <= 1'b0;
            o_first_active <= 1'b0;
            o_second_active <= 1'b0;
        end
        else
        begin
            o_extended_mode <= pin.range_mid;
            o_ddr <= ~pin.range_mid & pin.edge_mid;
            edge_rise <= pin.range_mid | pin.edge_select;
            o_interleave <= ~pin.range_mid & pin.cal_delay_mid;
            o_long_cal_delay <= ~pin.range_mid & pin.cal_delay_select;
            o_amplitude_reduced <= ~pin.range_mid & ~pin.amplitude_select;
            demux <= pin.demux;
            o_first_active <= ~pin.full_power_down;
            o_second_active <= ~pin.full_power_down &
                (~pin.second_channel_power_down | o_interleave);
        end
    end

    // ***********************************************************
    // Serial configuration port
    // ***********************************************************
    logic sclk_q;
    logic sclk_rise;
    logic [4:0] bit_cnt;
    logic [19:0] shift;
    logic [19:0] next_shift;
    logic frame_done;
    logic reg_write;

    assign sclk_rise = pin.amplitude_select & ~sclk_q;
    assign next_shift = {shift[18:0], pin.edge_select};
    assign frame_done = o_extended_mode & ~pin.cal_delay_select &
        sclk_rise & (bit_cnt == dcpc_pkg::SER_FRAME - 5'h01);
    assign reg_write = frame_done &
        (next_shift[19:16] == dcpc_pkg::CAL_REG_ADDR);

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            sclk_q <= 1'b0;
            bit_cnt <= '0;
            shift <= '0;
        end
        else
        begin
            sclk_q <= pin.amplitude_select;
            // Select is active low and framed; a high select aborts.
            if (~o_extended_mode | pin.cal_delay_select | frame_done)
                bit_cnt <= '0;
            else if (sclk_rise)
            begin
                bit_cnt <= bit_cnt + 5'h01;
                shift <= next_shift;
            end
        end
    end

    // ***********************************************************
    // Calibration
    // ***********************************************************
    logic [15:0] cal_reg;
    logic [15:0] low_cnt;
    logic [15:0] high_cnt;
    logic [15:0] run_cnt;
    logic low_ok;
    logic pin_start;
    logic reg_start;

    assign low_ok = low_cnt == dcpc_pkg::CAL_LOW_MIN;
    assign pin_start = pin.cal & low_ok &
        (high_cnt == dcpc_pkg::CAL_HIGH_MIN - 16'h0001);
    assign reg_start = reg_write &
        next_shift[dcpc_pkg::CAL_CMD_BIT];

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            low_cnt <= '0;
            high_cnt <= '0;
        end
        else if (~pin.cal)
        begin
            high_cnt <= '0;
            if (~low_ok)
                low_cnt <= low_cnt + 16'h0001;
        end
        else if (pin_start)
        begin
            low_cnt <= '0;
            high_cnt <= '0;
        end
        else if (low_ok)
            high_cnt <= high_cnt + 16'h0001;
        else
            low_cnt <= '0;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst | pin.full_power_down)
        begin
            o_cal_running <= 1'b0;
            run_cnt <= '0;
            cal_reg <= dcpc_pkg::CAL_REG_RESET;
        end
        else
        begin
            if (pin_start | reg_start)
            begin
                o_cal_running <= 1'b1;
                run_cnt <= CAL_RUN - 16'h0001;
            end
            else if (run_cnt != '0)
                run_cnt <= run_cnt - 16'h0001;
            else
                o_cal_running <= 1'b0;
            // A write that lands on the finishing cycle wins.
            if (reg_write)
                cal_reg <= next_shift[15:0];
            else if (o_cal_running & run_cnt == '0)
                cal_reg[dcpc_pkg::CAL_CMD_BIT] <= 1'b0;
        end
    end

    // ***********************************************************
    // Sample buffer
    // ***********************************************************
    dcpc_pkg::dcpc_word_t in_word;
    dcpc_pkg::dcpc_word_t out_word;
    logic out_valid;
    logic pop;

    assign in_word = '{first: {~i_sample.first[7], i_sample.first[6:0]},
        second: {~i_sample.second[7], i_sample.second[6:0]}};

    dcpc_fifo #(.WIDTH(16), .DEPTH(DEPTH)) u_fifo
    (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_in_valid(i_sample_valid & o_first_active),
        .i_in_data(in_word),
        .o_in_ready(o_sample_ready),
        .o_out_valid(out_valid),
        .o_out_data(out_word),
        .i_out_ready(pop)
    );

    // ***********************************************************
    // Output clock and resync
    // ***********************************************************
    logic [3:0] half_cnt;
    logic tick;
    logic upd;
    logic phase;
    logic rs_lvl;
    logic rs_q;
    logic resync_evt;

    assign tick = half_cnt == dcpc_pkg::OUT_CLK_HALF - 4'h1;
    assign upd = tick & (o_ddr | (~o_output_data_clock == edge_rise));
    assign pop = upd & out_valid & o_first_active;
    assign rs_lvl = pin.resync_style ? pin.resync_p :
        (pin.resync_p & ~pin.resync_n);
    assign resync_evt = rs_lvl & ~rs_q;

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            rs_q <= 1'b0;
        else
            rs_q <= rs_lvl;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst | ~o_first_active | resync_evt)
        begin
            half_cnt <= '0;
            o_output_data_clock <= 1'b0;
            phase <= 1'b0;
        end
        else if (tick)
        begin
            half_cnt <= '0;
            o_output_data_clock <= ~o_output_data_clock;
            if (pop)
                phase <= demux & ~phase;
        end
        else
            half_cnt <= half_cnt + 4'h1;
    end

    // ***********************************************************
    // Output buses
    // ***********************************************************
    dcpc_pkg::dcpc_word_t hold;

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst | ~o_first_active)
        begin
            o_first_channel_out <= '0;
            o_first_channel_out_b <= '0;
            o_second_out <= '0;
            o_second_out_b <= '0;
            hold <= '0;
        end
        else if (~o_second_active)
        begin
            o_second_out <= '0;
            o_second_out_b <= '0;
            if (pop & ~demux)
                o_first_channel_out <= out_word.first;
            else if (pop & ~phase)
                hold <= out_word;
            else if (pop)
            begin
                o_first_channel_out <= hold.first;
                o_first_channel_out_b <= out_word.first;
            end
        end
        else if (pop & ~demux)
        begin
            o_first_channel_out <= out_word.first;
            o_second_out <= out_word.second;
        end
        else if (pop & ~phase)
            hold <= out_word;
        else if (pop)
        begin
            o_first_channel_out <= hold.first;
            o_first_channel_out_b <= out_word.first;
            o_second_out <= hold.second;
            o_second_out_b <= out_word.second;
        end
    end

    // ***********************************************************
    // Checks
    // ***********************************************************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    property p_full_off;
        pin.full_power_down |=> ##1 (o_first_channel_out == 8'h00 &&
            o_second_out == 8'h00 && !o_output_data_clock);
    endproperty
    a_full_off: assert property (p_full_off)
        else $error("Outputs active in full power down.");

    // The first channel is judged one cycle earlier than the second bus,
    // so that a full power down that follows at once is not blamed here.
    property p_second_off;
        pin.second_channel_power_down && !pin.full_power_down &&
            !o_interleave && !pin.cal_delay_mid
            |=> o_first_active ##1 o_second_out == 8'h00;
    endproperty
    a_second_off: assert property (p_second_off)
        else $error("Second channel power down misbehaves.");

    property p_cal_pin;
        pin_start |-> $past(!pin.cal, 16'(dcpc_pkg::CAL_HIGH_MIN));
    endproperty
    a_cal_pin: assert property (p_cal_pin)
        else $error("Calibration started without low-high pattern.");

    property p_cal_reg;
        reg_start && !pin.full_power_down |=> o_cal_running;
    endproperty
    a_cal_reg: assert property (p_cal_reg)
        else $error("Register command did not start calibration.");

    property p_resync;
        resync_evt && o_first_active |=> !o_output_data_clock &&
            half_cnt == 4'h0 && !phase;
    endproperty
    a_resync: assert property (p_resync)
        else $error("Output clock not reset by resync.");

    property p_diff;
        !pin.resync_style && pin.resync_n |-> !resync_evt;
    endproperty
    a_diff: assert property (p_diff)
        else $error("Differential resync took single-ended pulse.");

    property p_demux;
        o_second_active && demux && $changed(o_first_channel_out_b)
            |-> $past(phase);
    endproperty
    a_demux: assert property (p_demux)
        else $error("Demux bus updated on a first word.");

    property p_nodemux;
        pop && !demux |=> o_first_channel_out == $past(out_word.first);
    endproperty
    a_nodemux: assert property (p_nodemux)
        else $error("Non-demux word not presented.");

    property p_edge;
        o_first_active && !o_ddr && $changed(o_first_channel_out) &&
            $past(o_first_active) |-> o_output_data_clock == $past(edge_rise);
    endproperty
    a_edge: assert property (p_edge)
        else $error("Data changed on the wrong clock edge.");

    property p_fmt;
        in_word.first[7] != i_sample.first[7];
    endproperty
    a_fmt: assert property (p_fmt)
        else $error("Sample not in offset binary.");

    c_cal_pin: cover property (pin_start);
    c_resync: cover property (resync_evt ##3 o_output_data_clock);
    c_demux: cover property (pop && demux && phase);
    c_ddr: cover property (o_ddr && pop);
endmodule

`default_nettype wire

// file: verification/dcpc_capture.sv
// Model of the capture logic that reads the converter output buses.
// Assumes it shares the system clock and only observes the device.
`timescale 1ns/1ns
`default_nettype none

module dcpc_capture
(
    input wire logic i_clk,
    input wire logic i_output_data_clock,
    input wire logic [7:0] i_first,
    input wire logic [7:0] i_second,
    output logic [7:0] o_last_first,
    output logic [7:0] o_last_second
);
    logic output_data_clock_d;

    // Words are taken on either output clock edge, which suits SDR and DDR.
    always_ff @(posedge i_clk)
    begin
        output_data_clock_d <= i_output_data_clock;
        if (output_data_clock_d != i_output_data_clock)
        begin
            o_last_first <= i_first;
            o_last_second <= i_second;
        end
    end
endmodule

`default_nettype wire

// file: verification/dcpc_top_tb.sv
// Self-checking bench of the converter pin control block.
// Assumes a 20 MHz clock and pins driven at the falling edge.
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, e) \
    begin \
        comparisons = comparisons + 1; \
        if ((a) !== (e)) \
        begin \
            err_count = err_count + 1; \
            $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); \
        end \
    end

`define WAIT(c) \
    begin \
        n = 0; \
        while (!(c) && n < 600) \
        begin \
            @(negedge clk); \
            n = n + 1; \
        end \
        if (n >= 600) \
        begin \
            err_count = err_count + 1; \
            end_sim(); \
        end \
    end

module dcpc_top_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    dcpc_pkg::dcpc_pins_t pins;
    logic valid = 1'b0;
    dcpc_pkg::dcpc_word_t sample = 16'h0000;
    logic ready, output_data_clock, act1, act2, cal_run, long_dly, amp_red;
    logic ext, ilv, ddr;
    logic [7:0] d1, d1b, d2, d2b;
    logic [7:0] cap1, cap2;
    int err_count = 0;
    int comparisons = 0;
    int n;
    logic [19:0] frame;

    always #25 clk = ~clk;

    dcpc_top #(.CAL_RUN(16'h0008)) dut
    (
        .i_clk(clk), .i_sys_rst(rst), .i_pins(pins),
        .i_sample_valid(valid), .i_sample(sample),
        .o_sample_ready(ready), .o_first_channel_out(d1),
        .o_first_channel_out_b(d1b), .o_second_out(d2),
        .o_second_out_b(d2b), .o_output_data_clock(output_data_clock),
        .o_first_active(act1), .o_second_active(act2),
        .o_cal_running(cal_run), .o_long_cal_delay(long_dly),
        .o_amplitude_reduced(amp_red), .o_extended_mode(ext),
        .o_interleave(ilv), .o_ddr(ddr)
    );

    dcpc_capture cap
    (
        .i_clk(clk), .i_output_data_clock(output_data_clock), .i_first(d1), .i_second(d2),
        .o_last_first(cap1), .o_last_second(cap2)
    );

    task automatic end_sim();
        if (err_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic settle();
        repeat (4) @(negedge clk);
    endtask

    task automatic push(input logic [15:0] w);
        sample = w;
        valid = 1'b1;
        `WAIT(ready === 1'b1)
        @(negedge clk);
        valid = 1'b0;
        @(negedge clk);
    endtask

    task automatic t_power();
        pins.second_channel_power_down = 1'b1;
        settle();
        `CHK(act2, 1'b0)
        `CHK(act1, 1'b1)
        pins.full_power_down = 1'b1;
        settle();
        `CHK({act1, act2}, 2'b00)
        pins.full_power_down = 1'b0;
        pins.second_channel_power_down = 1'b0;
        settle();
        `CHK({act1, act2}, 2'b11)
    endtask

    task automatic t_cal_pin();
        pins.cal = 1'b0;
        repeat (20) @(negedge clk);
        pins.cal = 1'b1;
        repeat (100) @(negedge clk);
        `CHK(cal_run, 1'b0)
        pins.cal = 1'b0;
        repeat (90) @(negedge clk);
        pins.cal = 1'b1;
        repeat (40) @(negedge clk);
        `CHK(cal_run, 1'b0)
        `WAIT(cal_run === 1'b1)
        `CHK(cal_run, 1'b1)
        repeat (10) @(negedge clk);
        `CHK(cal_run, 1'b0)
    endtask

    task automatic t_path();
        push(16'h05F0);
        `WAIT(d1 === 8'h85)
        `CHK(output_data_clock, 1'b1)
        `CHK(d1, 8'h85)
        `CHK(d2, 8'h70)
        @(negedge clk);
        `CHK({cap1, cap2}, 16'h8570)
        pins.demux = 1'b1;
        settle();
        push(16'h1020);
        push(16'h3040);
        `WAIT(d1b === 8'hB0)
        `CHK({d1, d1b}, 16'h90B0)
        `CHK({d2, d2b}, 16'hA0C0)
        pins.demux = 1'b0;
        settle();
    endtask

    task automatic t_modes();
        pins.edge_select = 1'b0;
        settle();
        push(16'h7F01);
        `WAIT(d1 === 8'hFF)
        `CHK(output_data_clock, 1'b0)
        pins.edge_select = 1'b1;
        pins.edge_mid = 1'b1;
        settle();
        `CHK(ddr, 1'b1)
        push(16'h0000);
        `WAIT(d1 === 8'h80)
        `CHK(d2, 8'h80)
        pins.edge_mid = 1'b0;
        pins.cal_delay_mid = 1'b1;
        pins.second_channel_power_down = 1'b1;
        settle();
        `CHK({ddr, ilv, act2}, 3'b011)
        pins.cal_delay_mid = 1'b0;
        pins.second_channel_power_down = 1'b0;
        pins.amplitude_select = 1'b0;
        settle();
        `CHK({ilv, amp_red, act2}, 3'b011)
        pins.amplitude_select = 1'b1;
        settle();
    endtask

    // Pulses the resync pins and records the output clock over four
    // cycles, starting at the cycle in which a resync would clear it.
    task automatic resync_seen(input logic n_level, output logic [3:0] seen);
        pins.resync_p = 1'b1;
        pins.resync_n = n_level;
        repeat (3) @(negedge clk);
        for (int i = 3; i >= 0; i--)
        begin
            seen[i] = output_data_clock;
            @(negedge clk);
        end
        pins.resync_p = 1'b0;
        pins.resync_n = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    // Calls start ten cycles apart, fourteen around the style change, so a
    // missed resync shows the free-running clock half a period out of step.
    task automatic t_resync();
        logic [3:0] seen;
        resync_seen(1'b0, seen);
        `CHK(seen, 4'h3)
        resync_seen(1'b0, seen);
        `CHK(seen, 4'h3)
        pins.resync_style = 1'b0;
        settle();
        resync_seen(1'b0, seen);
        `CHK(seen, 4'h3)
        resync_seen(1'b1, seen);
        `CHK(seen, 4'hC)
    endtask

    task automatic t_serial();
        pins.range_mid = 1'b1;
        settle();
        `CHK(ext, 1'b1)
        `CHK(long_dly, 1'b0)
        frame = {4'h0, 16'h0001};
        pins.cal_delay_select = 1'b0;
        // Serial clock period is eight system clocks; data moves while low.
        for (int i = 19; i >= 0; i--)
        begin
            pins.amplitude_select = 1'b0;
            pins.edge_select = frame[i];
            repeat (4) @(negedge clk);
            pins.amplitude_select = 1'b1;
            repeat (4) @(negedge clk);
        end
        pins.cal_delay_select = 1'b1;
        pins.edge_select = 1'b1;
        `WAIT(cal_run === 1'b1)
        `CHK(cal_run, 1'b1)
        pins.range_mid = 1'b0;
        repeat (20) @(negedge clk);
    endtask

    initial
    begin
        pins = '0;
        pins.amplitude_select = 1'b1;
        pins.cal_delay_select = 1'b1;
        pins.resync_style = 1'b1;
        pins.edge_select = 1'b1;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        settle();
        t_power();
        t_cal_pin();
        t_path();
        t_modes();
        t_resync();
        t_serial();
        end_sim();
    end
endmodule

`default_nettype wire
